// >>> src/dec_skip_pkg.sv
// Constants and carrier types for the decrement-and-skip execution unit
package dec_skip_pkg;

    // =========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PHASES_PER_CYCLE = 4;
    localparam int unsigned INSTR_CYCLE_NS = CLK_PERIOD_NS * PHASES_PER_CYCLE;

    // =========================================================
    // Instruction word fields
    localparam int unsigned OPC_MSB = 15;
    localparam int unsigned OPC_LSB = 10;
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned BANK_BIT = 8;
    localparam int unsigned FILE_MSB = 7;
    localparam int unsigned FILE_LSB = 0;
    localparam logic [5:0] OPC_SKIP_NONZERO = 6'h13;
    localparam logic [5:0] OPC_SKIP_ZERO = 6'h0b;

    // =========================================================
    // Data space
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned DEPTH = 4096;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // =========================================================
    // Reset values and phase codes
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_PROC,
        ST_WRITE
    } stage_t;

    typedef struct packed {
        logic [15:0] word;
        logic valid;
    } instr_t;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_port_t;

    typedef struct packed {
        logic done;
        logic skipping;
        logic [DATA_W-1:0] result;
        logic [DATA_W-1:0] w;
    } exec_status_t;

endpackage : dec_skip_pkg

// >>> src/file_ram.sv
// Data-space file register array with registered read data
`timescale 1ns/100ps
`default_nettype none
module file_ram
    import dec_skip_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Write port
    input wire wr_port_t wr_i,
    // Read port
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o
);

    logic [DATA_W-1:0] mem [DEPTH];

    // =========================================================
    // Storage, no reset on the array itself
    always_ff @(posedge mclk_i) begin
        if (wr_i.we) begin
            mem[wr_i.addr] <= wr_i.data;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule : file_ram
`default_nettype wire

// >>> src/dec_skip_exec.sv
// Execution unit for the decrement-file-and-skip byte instructions
//
// What this block does
// - Reads the addressed file register and forms its value minus one.
// - Destination bit 0 sends the result to W, 1 writes it back to f.
// - A nonzero result (zero for the skip-if-zero opcode) discards the next fetched word as a one-cycle NOP.
// - Bank bit 0 resolves the file address through the access bank.
// - Bank bit 1 forms the address from the bank select pointer and f.
// - Bank bit 0 with extended set on and f up to 95 uses indexed offset.
`timescale 1ns/100ps
`default_nettype none
module dec_skip_exec
    import dec_skip_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Instruction issue, sampled in phase Q1
    input wire instr_t instr_i,
    // Addressing context
    input wire logic [BANK_W-1:0] bank_select_pointer_i,
    input wire logic ext_set_en_i,
    input wire logic [ADDR_W-1:0] index_base_i,
    // Preload port into the file registers
    input wire wr_port_t load_i,
    // Status
    output exec_status_t status_o,
    output logic [1:0] phase_o,
    output logic [DATA_W-1:0] file_rd_data_o
);

    typedef struct packed {
        logic [1:0] phase;
        stage_t stage;
        logic dest_file;
        logic skip_on_zero;
        logic skip_next;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] result;
        wr_port_t wr;
        exec_status_t status;
    } state_t;

    // One instruction cycle is four clocks:
    //   Q1 edge  decode and latch the file address
    //   Q2 edge  array read of that address
    //   Q3 edge  data minus one
    //   Q4 edge  write-back, done and the skip decision
    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_NONZERO,
        KIND_ZERO
    } op_kind_t;

    state_t s_q;
    state_t s_d;
    logic [DATA_W-1:0] rd_data;
    wr_port_t ram_wr;
    op_kind_t issue_kind;
    logic issue_take;
    logic [ADDR_W-1:0] issue_addr;
    logic skip_decision;

    // =========================================================
    // Decode helpers
    function automatic op_kind_t opc_kind(input logic [15:0] word);
        logic [5:0] opc;
        opc = word[OPC_MSB:OPC_LSB];
        if (opc == OPC_SKIP_NONZERO) begin
            opc_kind = KIND_NONZERO;
        end else if (opc == OPC_SKIP_ZERO) begin
            opc_kind = KIND_ZERO;
        end else begin
            opc_kind = KIND_NONE;
        end
    endfunction : opc_kind

    function automatic logic [ADDR_W-1:0] file_addr(
        input logic [15:0] word,
        input logic [BANK_W-1:0] bank,
        input logic ext_en,
        input logic [ADDR_W-1:0] base
    );
        logic [7:0] f;
        logic indexed;
        f = word[FILE_MSB:FILE_LSB];
        indexed = ext_en && (f <= INDEXED_LIMIT);
        if (word[BANK_BIT]) begin
            // Pointer picks one general purpose file bank
            file_addr = {bank, f};
        end else if (indexed) begin
            // Offset from the base wraps inside the data space
            file_addr = base + {4'h0, f};
        end else if (f < ACCESS_SPLIT) begin
            file_addr = {ACCESS_LOW_BANK, f};
        end else begin
            file_addr = {ACCESS_HIGH_BANK, f};
        end
    endfunction : file_addr

    // =========================================================
    // Issue decode
    // Combinational on purpose: the word only has to stand at the Q1 edge
    always_comb begin
        issue_kind = opc_kind(instr_i.word);
        issue_addr = file_addr(instr_i.word, bank_select_pointer_i,
            ext_set_en_i, index_base_i);
        issue_take = instr_i.valid && (issue_kind != KIND_NONE);
    end

    // Skip-if-zero is the sibling of the nonzero test
    always_comb begin
        if (s_q.skip_on_zero) begin
            skip_decision = (s_q.result == 8'h00);
        end else begin
            skip_decision = (s_q.result != 8'h00);
        end
    end

    // =========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.phase = s_q.phase + 2'h1;
        s_d.wr.we = 1'b0;
        s_d.status.done = 1'b0;
        if (s_q.phase == PHASE_Q4) begin
            s_d.status.skipping = 1'b0;
        end
        unique case (s_q.stage)
            ST_IDLE: begin
                if (s_q.phase == PHASE_Q1) begin
                    if (s_q.skip_next) begin
                        // Fetched word is thrown away, cycle runs as a NOP
                        s_d.skip_next = 1'b0;
                        s_d.status.skipping = 1'b1;
                    end else if (issue_take) begin
                        s_d.stage = ST_READ;
                        s_d.dest_file = instr_i.word[DEST_BIT];
                        s_d.skip_on_zero = (issue_kind == KIND_ZERO);
                        s_d.addr = issue_addr;
                    end
                end
            end
            ST_READ: begin
                // The array samples the held address on this edge
                s_d.stage = ST_PROC;
            end
            ST_PROC: begin
                s_d.result = rd_data - 8'h01;
                s_d.stage = ST_WRITE;
            end
            ST_WRITE: begin
                s_d.stage = ST_IDLE;
                s_d.status.done = 1'b1;
                s_d.status.result = s_q.result;
                if (s_q.dest_file) begin
                    s_d.wr.we = 1'b1;
                    s_d.wr.addr = s_q.addr;
                    s_d.wr.data = s_q.result;
                end else begin
                    s_d.status.w = s_q.result;
                end
                s_d.skip_next = skip_decision;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '{
                phase: PHASE_Q1,
                stage: ST_IDLE,
                dest_file: 1'b0,
                skip_on_zero: 1'b0,
                skip_next: 1'b0,
                addr: '0,
                result: '0,
                wr: '0,
                status: '{
                    done: 1'b0,
                    skipping: 1'b0,
                    result: '0,
                    w: W_RESET
                }
            };
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // File register array; core write-back wins over the preload port
    // A preload offered in the write-back clock is lost: load while idle
    always_comb begin
        if (s_q.wr.we) begin
            ram_wr = s_q.wr;
        end else begin
            ram_wr = load_i;
        end
    end

    // Write-back lands on the Q1 edge and the next read a clock later,
    // so back-to-back work on one file register sees the new value

    file_ram u_ram (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .wr_i(ram_wr),
        .rd_addr_i(s_q.addr),
        .rd_data_o(rd_data)
    );

    // =========================================================
    // Outputs, all straight from registers
    assign status_o = s_q.status;
    assign phase_o = s_q.phase;
    assign file_rd_data_o = rd_data;

endmodule : dec_skip_exec
`default_nettype wire

// >>> tb/dec_skip_exec_chk.sv
// Port-level checker for the decrement-and-skip unit
`timescale 1ns/100ps
`default_nettype none
module dec_skip_exec_chk
    import dec_skip_pkg::*;
(
    // Watched ports
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire instr_t instr_i,
    input wire exec_status_t status_o,
    input wire logic [1:0] phase_o
);
    wire logic [5:0] opc = instr_i.word[OPC_MSB:OPC_LSB];
    wire logic dst = instr_i.word[DEST_BIT];
    wire logic vld = instr_i.valid;
    wire logic dn = status_o.done;
    wire logic sk = status_o.skipping;
    wire logic [7:0] wv = status_o.w;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================
    // Cycle framing and completion
    // Phase runs free from the first edge after reset
    chk_phase_step: assert property (
        $past(rstn_i) |-> phase_o == 2'($past(phase_o) + 2'h1))
        else $error("phase skipped");
    chk_done_gap: assert property (
        dn |=> !dn [*3]) else $error("done too close");
    // Done is seen four samples after the Q1 edge that took the word
    chk_op_decode: assert property (
        dn |-> $past(vld, 4) && ($past(opc, 4) == OPC_SKIP_NONZERO
        || $past(opc, 4) == OPC_SKIP_ZERO)) else $error("bad opcode ran");
    // ==========================================
    // Skip decision and destination
    chk_skip_nz: assert property (
        dn && $past(opc, 4) == OPC_SKIP_NONZERO |=>
        sk == (status_o.result != 8'h00)) else $error("nonzero skip");
    chk_skip_z: assert property (
        dn && $past(opc, 4) == OPC_SKIP_ZERO |=>
        sk == (status_o.result == 8'h00)) else $error("zero skip");
    chk_dest_w: assert property (
        dn && !$past(dst, 4) |-> wv == status_o.result)
        else $error("W not loaded");
    chk_dest_f: assert property (
        dn && $past(dst, 4) |-> wv == $past(wv)) else $error("W disturbed");
    // Skip flag covers Q2 to Q4 of the discarded cycle
    chk_skip_len: assert property (
        $rose(sk) |-> sk [*3] ##1 !sk) else $error("skip length");
    chk_skip_cause: assert property (
        $rose(sk) |-> $past(dn)) else $error("skip without completion");
endmodule : dec_skip_exec_chk
`default_nettype wire

// >>> tb/tb_top.sv
// Random and corner-case bench for the decrement-and-skip unit
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import dec_skip_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    instr_t instr_i = '0;
    logic [BANK_W-1:0] bsp = '0;
    logic ext_en = 1'b0;
    logic [ADDR_W-1:0] base = '0;
    wr_port_t load_i = '0;
    exec_status_t status_o;
    logic [1:0] phase_o;
    logic [DATA_W-1:0] rd_data;
    int error_cnt = 0;
    int num_checks = 0;
    logic [15:0] seed = 16'h0038;
    logic [7:0] mem [DEPTH];
    logic [7:0] mw = W_RESET;
    dec_skip_exec uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .instr_i(instr_i),
        .bank_select_pointer_i(bsp), .ext_set_en_i(ext_en),
        .index_base_i(base), .load_i(load_i), .status_o(status_o),
        .phase_o(phase_o), .file_rd_data_o(rd_data));
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // ==========================================
    // Helpers
    function automatic logic [15:0] nxt(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    function automatic logic [11:0] eaddr(logic [15:0] w, logic [3:0] b,
        logic e, logic [11:0] bs);
        if (w[BANK_BIT]) return {b, w[7:0]};
        if (e && w[7:0] <= INDEXED_LIMIT) return bs + 12'(w[7:0]);
        return {(w[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK :
            ACCESS_HIGH_BANK, w[7:0]};
    endfunction : eaddr
    task automatic chk8(logic [7:0] g, logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %0t byte got %h exp %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(logic g, logic e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %0t flag got %b exp %b", $time, g, e);
        end
    endtask : chk1
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    // Hang guard, well past the expected 5700 cycles
    initial begin
        #(20000 * CLK_PERIOD_NS);
        error_cnt++;
        wrap_up();
    end
    // ==========================================
    // Preload, then issue a stream with skip drops
    initial begin
        logic [15:0] cur, nx;
        logic [11:0] ca, na;
        logic [7:0] v;
        logic live, sk;
        live = 1'b0;
        cur = '0;
        ca = '0;
        repeat (16) @(negedge mclk_i);
        rstn_i = 1'b1;
        for (int i = 0; i < DEPTH; i++) begin
            seed = nxt(seed);
            mem[i] = (i % 8 == 0) ? 8'h01 : (i % 8 == 5) ? 8'h00 : seed[7:0];
            load_i = '{we: 1'b1, addr: ADDR_W'(i), data: mem[i]};
            @(negedge mclk_i);
        end
        load_i.we = 1'b0;
        for (int n = 0; n < 400; n++) begin
            for (int k = 0; k < 8 && phase_o !== PHASE_Q1; k++)
                @(negedge mclk_i);
            // Done stands in the clock just before the next Q1 edge
            chk1(status_o.done, live);
            seed = nxt(seed);
            nx = seed;
            nx[15:10] = seed[0] ? OPC_SKIP_NONZERO : OPC_SKIP_ZERO;
            if (seed[3:1] == 3'h0) nx[15:10] = 6'h00;
            // Every fourth word reuses the last address to read back f
            if (n % 4 == 1) nx[8:0] = cur[8:0];
            else begin
                seed = nxt(seed);
                bsp = seed[3:0];
                ext_en = seed[4];
                base = seed[15:4];
            end
            na = eaddr(nx, bsp, ext_en, base);
            instr_i = '{word: nx, valid: 1'b1};
            @(negedge mclk_i);
            sk = 1'b0;
            if (live) begin
                v = mem[ca] - 8'h01;
                chk8(status_o.result, v);
                if (cur[DEST_BIT]) mem[ca] = v;
                else mw = v;
                sk = (cur[15:10] == OPC_SKIP_NONZERO) ? v != 8'h00 : v == 8'h00;
            end
            chk8(status_o.w, mw);
            chk1(status_o.skipping, sk);
            live = !sk && (nx[15:10] == OPC_SKIP_NONZERO ||
                nx[15:10] == OPC_SKIP_ZERO);
            cur = nx;
            ca = na;
            instr_i.valid = 1'b0;
            // Array read of the taken address shows one clock after Q1
            @(negedge mclk_i);
            if (live) chk8(rd_data, mem[na]);
        end
        wrap_up();
    end
endmodule : tb_top
bind dec_skip_exec dec_skip_exec_chk chk_i (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .instr_i(instr_i), .status_o(status_o),
    .phase_o(phase_o));
`default_nettype wire
